// ===== src/spcm_cfg_map.sv
// Configuration capability map of one switch port, answered over configuration requests
// Operation
// [RULE_01] The port offers an extended region with error reporting, virtual channel and power budget structures.
// [RULE_02] The first extended structure and its header start at byte 100h.
// [RULE_03] All further extended structures sit above 0FFh.
// [RULE_04] Dword 100h reads identifier 0001h with next pointer 140h.
// [RULE_05] Dword 140h reads identifier 0002h with next pointer 20Ch.
// [RULE_06] Dword 220h reads identifier 000Dh with next pointer 000h, ending the chain.
// [RULE_07] Dword 230h reads identifier 0018h with next pointer 000h, and 234h holds the latency values and scales.
// [RULE_08] The arbitration table offset field of dword 148h reads 3.
// [RULE_09] The port arbitration table offset field of dword 150h reads 4.
// [RULE_10] The port arbitration table offset field of dword 15Ch reads 6.
// [RULE_11] A 32-phase channel arbitration table lives at 170h to 17Ch.
// [RULE_12] A 128-phase port arbitration table for channel 0 lives at 180h to 1BCh.
// [RULE_13] A 128-phase port arbitration table for channel 1 lives at 1C0h to 1FCh.
// [RULE_14] Dword 20Ch reads identifier 0004h and points to 220h or 230h by port strap.
// [RULE_15] Dword B0h reads identifier 0Dh pointing to C0h, and C0h reads identifier 10h pointing to 00h.
// [RULE_16] Reserved offsets read zero and ignore writes.
`timescale 1ns/1ns
module spcm_cfg_map (
    input  wire logic              clk,
    input  wire logic              rst,
    input  spcm_pkg::spcm_req_t    cfg_req,
    input  wire logic [31:0]       ue_event,
    input  wire logic [31:0]       ce_event,
    input  wire logic [127:0]      hdr_log,
    input  wire logic              ltr_route_pin,
    output spcm_pkg::spcm_rsp_t    cfg_rsp,
    output logic                   err_pending,
    output logic                   ltr_route
);
    import spcm_pkg::*;

    spcm_state_t               st_ff;
    spcm_state_t               nxt_st;
    logic [ARB_WORDS-1:0]      arb_hit;
    logic [31:0]               wmask;
    logic [31:0]               rd_val;
    logic                      wr_go;
    logic [11:0]               dw;

    // Byte enables widened to a bit mask
    assign wmask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
    assign wr_go = cfg_req.req && cfg_req.wr;
    assign dw    = {cfg_req.addr[11:2], 2'b00};

    // Merge of written bytes into the writable bits only
    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] bm, input logic [31:0] rw);
        wr_merge = (old & ~(bm & rw)) | (wd & bm & rw);
    endfunction

    // Extended header: id, version, next pointer
    function automatic logic [31:0] ext_hdr(input logic [15:0] id, input logic [11:0] nxt);
        ext_hdr = {nxt, CAP_VER, id};
    endfunction

    // Per-entry decode of the three arbitration tables
    genvar gi;
    generate
        for (gi = 0; gi < ARB_WORDS; gi++)
        begin : g_arb
            if (gi < PA0_IDX)
            begin : g_vc
                assign arb_hit[gi] = (dw == OFS_VC_ARB + 12'(4 * gi)); // see [RULE_11]
            end
            else if (gi < PA1_IDX)
            begin : g_p0
                assign arb_hit[gi] = (dw == OFS_PA0 + 12'(4 * (gi - PA0_IDX))); // see [RULE_12]
            end
            else
            begin : g_p1
                assign arb_hit[gi] = (dw == OFS_PA1 + 12'(4 * (gi - PA1_IDX))); // see [RULE_13]
            end
        end
    endgenerate

    // Read multiplexer; offsets neither listed nor inside an arbitration table fall through to zero
    always_comb
    begin
        rd_val = RST_ZERO; // see [RULE_16]
        unique case (dw)
            OFS_PHY3:     rd_val = st_ff.phy3;
            OFS_PHY_TX:   rd_val = st_ff.phy_tx;
            OFS_OP_BUF:   rd_val = st_ff.op_buf;
            OFS_SSID_HDR: rd_val = {16'h0000, NXT_SSID, CID_SSID}; // see [RULE_15]
            OFS_SSID:     rd_val = SSID_VAL;
            OFS_GPIO:     rd_val = st_ff.gpio;
            OFS_ROM:      rd_val = st_ff.rom;
            OFS_EXP_HDR:  rd_val = {16'h0000, NXT_EXP, CID_EXP}; // see [RULE_15]
            OFS_DEV_CAP:  rd_val = RO_CAP_VAL;
            OFS_DEV_CTL:  rd_val = st_ff.dev_ctl;
            OFS_LNK_CAP:  rd_val = RO_CAP_VAL;
            OFS_LNK_CTL:  rd_val = st_ff.lnk_ctl;
            OFS_SLT_CAP:  rd_val = RO_CAP_VAL;
            OFS_SLT_CTL:  rd_val = st_ff.slt_ctl;
            OFS_DEV_CAP2: rd_val = RO_CAP_VAL;
            OFS_DEV_CTL2: rd_val = st_ff.dev_ctl2;
            OFS_LNK_CAP2: rd_val = RO_CAP_VAL;
            OFS_LNK_CTL2: rd_val = st_ff.lnk_ctl2;
            OFS_SLT_CAP2: rd_val = RO_CAP_VAL;
            OFS_AER_HDR:  rd_val = ext_hdr(XID_AER, XNXT_AER); // see [RULE_01] see [RULE_02] see [RULE_04]
            OFS_UE_STS:   rd_val = st_ff.ue_sts;
            OFS_UE_MSK:   rd_val = st_ff.ue_msk;
            OFS_UE_SEV:   rd_val = st_ff.ue_sev;
            OFS_CE_STS:   rd_val = st_ff.ce_sts;
            OFS_CE_MSK:   rd_val = st_ff.ce_msk;
            OFS_AER_CTL:  rd_val = st_ff.aer_ctl;
            OFS_HLOG0:          rd_val = hdr_log[31:0];
            OFS_HLOG0 + 12'h4:  rd_val = hdr_log[63:32];
            OFS_HLOG0 + 12'h8:  rd_val = hdr_log[95:64];
            OFS_HLOG0 + 12'hC:  rd_val = hdr_log[127:96];
            OFS_VC_HDR:   rd_val = ext_hdr(XID_VC, XNXT_VC); // see [RULE_03] see [RULE_05]
            OFS_VC_CAP1:  rd_val = RO_CAP_VAL;
            OFS_VC_CAP2:  rd_val = {VC_ARB_OFS, 24'h000000}; // see [RULE_08]
            OFS_VC_CTL:   rd_val = st_ff.vc_ctl;
            OFS_VC0_CAP:  rd_val = {PA0_OFS, 24'h000000}; // see [RULE_09]
            OFS_VC0_CTL:  rd_val = st_ff.vc0_ctl;
            OFS_VC0_STS:  rd_val = RO_CAP_VAL;
            OFS_VC1_CAP:  rd_val = {PA1_OFS, 24'h000000}; // see [RULE_10]
            OFS_VC1_CTL:  rd_val = st_ff.vc1_ctl;
            OFS_VC1_STS:  rd_val = RO_CAP_VAL;
            OFS_PB_HDR:   rd_val = ext_hdr(XID_PB, st_ff.ltr_sel ? XNXT_PB_LTR : XNXT_PB_ACS); // see [RULE_14]
            OFS_PB_SEL:   rd_val = st_ff.pb_sel;
            OFS_PB_DATA:  rd_val = PB_DATA_VAL;
            OFS_PB_CAP:   rd_val = st_ff.pb_cap;
            OFS_ACS_HDR:  rd_val = ext_hdr(XID_ACS, XNXT_END); // see [RULE_06]
            OFS_ACS_CTL:  rd_val = st_ff.acs_ctl;
            OFS_EGRESS:   rd_val = st_ff.egress;
            OFS_LTR_HDR:  rd_val = ext_hdr(XID_LTR, XNXT_END); // see [RULE_07]
            OFS_LTR_VAL:  rd_val = st_ff.ltr_val; // see [RULE_07]
            default:
            begin
                for (int i = 0; i < ARB_WORDS; i++)
                begin
                    if (arb_hit[i])
                    begin
                        rd_val = st_ff.arb[i];
                    end
                end
            end
        endcase
    end

    // Next state: writes, sticky error bits, strap filter, answer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rsp.ack   = cfg_req.req;
        nxt_st.rsp.rdata = (cfg_req.req && !cfg_req.wr) ? rd_val : RST_ZERO;
        if (wr_go)
        begin
            unique case (dw)
                OFS_PHY3:     nxt_st.phy3     = wr_merge(st_ff.phy3, cfg_req.wdata, wmask, WM_FULL);
                OFS_PHY_TX:   nxt_st.phy_tx   = wr_merge(st_ff.phy_tx, cfg_req.wdata, wmask, WM_FULL);
                OFS_OP_BUF:   nxt_st.op_buf   = wr_merge(st_ff.op_buf, cfg_req.wdata, wmask, WM_FULL);
                OFS_GPIO:     nxt_st.gpio     = wr_merge(st_ff.gpio, cfg_req.wdata, wmask, WM_FULL);
                OFS_ROM:      nxt_st.rom      = wr_merge(st_ff.rom, cfg_req.wdata, wmask, WM_FULL);
                OFS_DEV_CTL:  nxt_st.dev_ctl  = wr_merge(st_ff.dev_ctl, cfg_req.wdata, wmask, WM_LOW);
                OFS_LNK_CTL:  nxt_st.lnk_ctl  = wr_merge(st_ff.lnk_ctl, cfg_req.wdata, wmask, WM_LOW);
                OFS_SLT_CTL:  nxt_st.slt_ctl  = wr_merge(st_ff.slt_ctl, cfg_req.wdata, wmask, WM_LOW);
                OFS_DEV_CTL2: nxt_st.dev_ctl2 = wr_merge(st_ff.dev_ctl2, cfg_req.wdata, wmask, WM_LOW);
                OFS_LNK_CTL2: nxt_st.lnk_ctl2 = wr_merge(st_ff.lnk_ctl2, cfg_req.wdata, wmask, WM_LOW);
                OFS_UE_STS:   nxt_st.ue_sts   = st_ff.ue_sts & ~(cfg_req.wdata & wmask);
                OFS_UE_MSK:   nxt_st.ue_msk   = wr_merge(st_ff.ue_msk, cfg_req.wdata, wmask, WM_FULL);
                OFS_UE_SEV:   nxt_st.ue_sev   = wr_merge(st_ff.ue_sev, cfg_req.wdata, wmask, WM_FULL);
                OFS_CE_STS:   nxt_st.ce_sts   = st_ff.ce_sts & ~(cfg_req.wdata & wmask);
                OFS_CE_MSK:   nxt_st.ce_msk   = wr_merge(st_ff.ce_msk, cfg_req.wdata, wmask, WM_FULL);
                OFS_AER_CTL:  nxt_st.aer_ctl  = wr_merge(st_ff.aer_ctl, cfg_req.wdata, wmask, WM_FULL);
                OFS_VC_CTL:   nxt_st.vc_ctl   = wr_merge(st_ff.vc_ctl, cfg_req.wdata, wmask, WM_LOW);
                OFS_VC0_CTL:  nxt_st.vc0_ctl  = wr_merge(st_ff.vc0_ctl, cfg_req.wdata, wmask, WM_FULL);
                OFS_VC1_CTL:  nxt_st.vc1_ctl  = wr_merge(st_ff.vc1_ctl, cfg_req.wdata, wmask, WM_FULL);
                OFS_PB_SEL:   nxt_st.pb_sel   = wr_merge(st_ff.pb_sel, cfg_req.wdata, wmask, WM_BYTE);
                OFS_PB_CAP:   nxt_st.pb_cap   = wr_merge(st_ff.pb_cap, cfg_req.wdata, wmask, WM_BYTE);
                OFS_ACS_CTL:  nxt_st.acs_ctl  = wr_merge(st_ff.acs_ctl, cfg_req.wdata, wmask, WM_HIGH);
                OFS_EGRESS:   nxt_st.egress   = wr_merge(st_ff.egress, cfg_req.wdata, wmask, WM_BYTE);
                OFS_LTR_VAL:  nxt_st.ltr_val  = wr_merge(st_ff.ltr_val, cfg_req.wdata, wmask, WM_FULL);
                default:
                begin
                    // Arbitration tables; anything else, read-only or reserved, is dropped
                    for (int i = 0; i < ARB_WORDS; i++)
                    begin
                        if (arb_hit[i])
                        begin
                            nxt_st.arb[i] = wr_merge(st_ff.arb[i], cfg_req.wdata, wmask, WM_FULL); // see [RULE_11]
                        end
                    end
                end
            endcase
        end
        // Hardware set applied after the clear, so a same-cycle event survives
        nxt_st.ue_sts   = nxt_st.ue_sts | ue_event;
        nxt_st.ce_sts   = nxt_st.ce_sts | ce_event;
        nxt_st.err_pend = |((st_ff.ue_sts & ~st_ff.ue_msk) | (st_ff.ce_sts & ~st_ff.ce_msk));
        // Strap filter: change accepted when second and third stage agree
        nxt_st.ltr_sync = {st_ff.ltr_sync[1:0], ltr_route_pin};
        if (st_ff.ltr_sync[1] == st_ff.ltr_sync[2])
        begin
            nxt_st.ltr_sel = st_ff.ltr_sync[2]; // see [RULE_14]
        end
    end

    // State register, all cleared by synchronous reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_rsp     = st_ff.rsp;
    assign err_pending = st_ff.err_pend;
    assign ltr_route   = st_ff.ltr_sel;

    // Checks of the capability chain and storage
    function automatic logic rd_at(input spcm_req_t r, input logic [11:0] a);
        rd_at = r.req && !r.wr && (r.addr[11:2] == a[11:2]);
    endfunction

    chk_aer_header: assert property (@(posedge clk) disable iff (rst) // see [RULE_04]
        rd_at(cfg_req, OFS_AER_HDR) |=> cfg_rsp.ack && cfg_rsp.rdata == {XNXT_AER, CAP_VER, XID_AER})
        else $error("error reporting header wrong");
    chk_vc_header: assert property (@(posedge clk) disable iff (rst) // see [RULE_05]
        rd_at(cfg_req, OFS_VC_HDR) |=> cfg_rsp.rdata[31:20] == XNXT_VC && cfg_rsp.rdata[15:0] == XID_VC)
        else $error("channel header wrong");
    chk_acs_header: assert property (@(posedge clk) disable iff (rst) // see [RULE_06]
        rd_at(cfg_req, OFS_ACS_HDR) |=> cfg_rsp.rdata[31:20] == XNXT_END && cfg_rsp.rdata[15:0] == XID_ACS)
        else $error("access control header wrong");
    chk_ltr_header: assert property (@(posedge clk) disable iff (rst) // see [RULE_07]
        rd_at(cfg_req, OFS_LTR_HDR) |=> cfg_rsp.rdata[31:20] == XNXT_END && cfg_rsp.rdata[15:0] == XID_LTR)
        else $error("latency header wrong");
    chk_arb_offsets: assert property (@(posedge clk) disable iff (rst) // see [RULE_08] see [RULE_09] see [RULE_10]
        (rd_at(cfg_req, OFS_VC_CAP2) |=> cfg_rsp.rdata[31:24] == VC_ARB_OFS) and
        (rd_at(cfg_req, OFS_VC0_CAP) |=> cfg_rsp.rdata[31:24] == PA0_OFS) and
        (rd_at(cfg_req, OFS_VC1_CAP) |=> cfg_rsp.rdata[31:24] == PA1_OFS))
        else $error("table offset field wrong");
    chk_pb_pointer: assert property (@(posedge clk) disable iff (rst) // see [RULE_14]
        rd_at(cfg_req, OFS_PB_HDR) |=> cfg_rsp.rdata[15:0] == XID_PB &&
        cfg_rsp.rdata[31:20] == ($past(ltr_route) ? XNXT_PB_LTR : XNXT_PB_ACS))
        else $error("power budget header wrong");
    chk_legacy_caps: assert property (@(posedge clk) disable iff (rst) // see [RULE_15]
        (rd_at(cfg_req, OFS_SSID_HDR) |=> cfg_rsp.rdata == {16'h0000, NXT_SSID, CID_SSID}) and
        (rd_at(cfg_req, OFS_EXP_HDR) |=> cfg_rsp.rdata == {16'h0000, NXT_EXP, CID_EXP}))
        else $error("legacy capability header wrong");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst) // see [RULE_16]
        (rd_at(cfg_req, 12'h09C) || rd_at(cfg_req, 12'h200) || rd_at(cfg_req, 12'h12C)) |=> cfg_rsp.rdata == 32'h0)
        else $error("reserved offset not zero");
    chk_arb_readback: assert property (@(posedge clk) disable iff (rst) // see [RULE_11] see [RULE_12] see [RULE_13]
        (wr_go && cfg_req.be == 4'hF && cfg_req.addr >= OFS_VC_ARB && cfg_req.addr < 12'h200)
        ##1 (cfg_req.req && !cfg_req.wr && cfg_req.addr[11:2] == $past(cfg_req.addr[11:2]))
        |=> cfg_rsp.rdata == $past(cfg_req.wdata, 2))
        else $error("arbitration table lost data");
    chk_event_wins: assert property (@(posedge clk) disable iff (rst) // see [RULE_01]
        ue_event != 32'h0 |=> (st_ff.ue_sts & $past(ue_event)) == $past(ue_event))
        else $error("error event lost against clear");
    chk_ext_region: assert property (@(posedge clk) disable iff (rst) // see [RULE_01] see [RULE_02] see [RULE_03]
        rd_at(cfg_req, EXT_BASE) |=> cfg_rsp.rdata[31:20] > 12'h0FF)
        else $error("extended chain leaves region");
    chk_ack_follows: assert property (@(posedge clk) disable iff (rst) // see [RULE_01]
        cfg_rsp.ack == $past(cfg_req.req))
        else $error("answer does not follow request");
    chk_write_quiet: assert property (@(posedge clk) disable iff (rst) // see [RULE_16]
        cfg_req.req && cfg_req.wr |=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0)
        else $error("write answer carries data");
    chk_header_log: assert property (@(posedge clk) disable iff (rst) // see [RULE_01]
        rd_at(cfg_req, OFS_HLOG0) |=> cfg_rsp.rdata == $past(hdr_log[31:0]))
        else $error("header log dword wrong");
    // A strap change must have been seen by both late stages first
    chk_strap_filter: assert property (@(posedge clk) disable iff (rst) // see [RULE_14]
        $changed(ltr_route) |-> ltr_route == $past(ltr_route_pin, 3) && ltr_route == $past(ltr_route_pin, 4))
        else $error("strap change not filtered");
    chk_strap_settles: assert property (@(posedge clk) disable iff (rst) // see [RULE_14]
        (ltr_route_pin [*5] |-> ltr_route) and (!ltr_route_pin [*5] |-> !ltr_route))
        else $error("strap filter did not settle");

    cov_write_arb: cover property (@(posedge clk) disable iff (rst) wr_go && |arb_hit);
    cov_clear_race: cover property (@(posedge clk) disable iff (rst)
        wr_go && dw == OFS_UE_STS && ue_event != 32'h0);
    cov_pb_to_ltr: cover property (@(posedge clk) disable iff (rst) rd_at(cfg_req, OFS_PB_HDR) && ltr_route);
    cov_back_to_back: cover property (@(posedge clk) disable iff (rst) cfg_req.req [*3]);
    cov_err_raised: cover property (@(posedge clk) disable iff (rst) $rose(err_pending));

endmodule

// ===== src/spcm_pkg.sv
// Constants and carriers for the switch port configuration capability map
package spcm_pkg;

    // Configuration request and answer carriers
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } spcm_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } spcm_rsp_t;

    // Dword offsets of the map
    localparam logic [11:0] OFS_PHY3     = 12'h090;
    localparam logic [11:0] OFS_PHY_TX   = 12'h094;
    localparam logic [11:0] OFS_OP_BUF   = 12'h098;
    localparam logic [11:0] OFS_SSID_HDR = 12'h0B0;
    localparam logic [11:0] OFS_SSID     = 12'h0B4;
    localparam logic [11:0] OFS_GPIO     = 12'h0B8;
    localparam logic [11:0] OFS_ROM      = 12'h0BC;
    localparam logic [11:0] OFS_EXP_HDR  = 12'h0C0;
    localparam logic [11:0] OFS_DEV_CAP  = 12'h0C4;
    localparam logic [11:0] OFS_DEV_CTL  = 12'h0C8;
    localparam logic [11:0] OFS_LNK_CAP  = 12'h0CC;
    localparam logic [11:0] OFS_LNK_CTL  = 12'h0D0;
    localparam logic [11:0] OFS_SLT_CAP  = 12'h0D4;
    localparam logic [11:0] OFS_SLT_CTL  = 12'h0D8;
    localparam logic [11:0] OFS_DEV_CAP2 = 12'h0E4;
    localparam logic [11:0] OFS_DEV_CTL2 = 12'h0E8;
    localparam logic [11:0] OFS_LNK_CAP2 = 12'h0EC;
    localparam logic [11:0] OFS_LNK_CTL2 = 12'h0F0;
    localparam logic [11:0] OFS_SLT_CAP2 = 12'h0F4;
    localparam logic [11:0] OFS_AER_HDR  = 12'h100;
    localparam logic [11:0] OFS_UE_STS   = 12'h104;
    localparam logic [11:0] OFS_UE_MSK   = 12'h108;
    localparam logic [11:0] OFS_UE_SEV   = 12'h10C;
    localparam logic [11:0] OFS_CE_STS   = 12'h110;
    localparam logic [11:0] OFS_CE_MSK   = 12'h114;
    localparam logic [11:0] OFS_AER_CTL  = 12'h118;
    localparam logic [11:0] OFS_HLOG0    = 12'h11C;
    localparam logic [11:0] OFS_VC_HDR   = 12'h140;
    localparam logic [11:0] OFS_VC_CAP1  = 12'h144;
    localparam logic [11:0] OFS_VC_CAP2  = 12'h148;
    localparam logic [11:0] OFS_VC_CTL   = 12'h14C;
    localparam logic [11:0] OFS_VC0_CAP  = 12'h150;
    localparam logic [11:0] OFS_VC0_CTL  = 12'h154;
    localparam logic [11:0] OFS_VC0_STS  = 12'h158;
    localparam logic [11:0] OFS_VC1_CAP  = 12'h15C;
    localparam logic [11:0] OFS_VC1_CTL  = 12'h160;
    localparam logic [11:0] OFS_VC1_STS  = 12'h164;
    localparam logic [11:0] OFS_VC_ARB   = 12'h170;
    localparam logic [11:0] OFS_PA0      = 12'h180;
    localparam logic [11:0] OFS_PA1      = 12'h1C0;
    localparam logic [11:0] OFS_PB_HDR   = 12'h20C;
    localparam logic [11:0] OFS_PB_SEL   = 12'h210;
    localparam logic [11:0] OFS_PB_DATA  = 12'h214;
    localparam logic [11:0] OFS_PB_CAP   = 12'h218;
    localparam logic [11:0] OFS_ACS_HDR  = 12'h220;
    localparam logic [11:0] OFS_ACS_CTL  = 12'h224;
    localparam logic [11:0] OFS_EGRESS   = 12'h228;
    localparam logic [11:0] OFS_LTR_HDR  = 12'h230;
    localparam logic [11:0] OFS_LTR_VAL  = 12'h234;
    localparam logic [11:0] EXT_BASE     = 12'h100;

    // Capability identifiers, versions and pointers
    localparam logic [7:0]  CID_SSID     = 8'h0D;
    localparam logic [7:0]  CID_EXP      = 8'h10;
    localparam logic [7:0]  NXT_SSID     = 8'hC0;
    localparam logic [7:0]  NXT_EXP      = 8'h00;
    localparam logic [15:0] XID_AER      = 16'h0001;
    localparam logic [15:0] XID_VC       = 16'h0002;
    localparam logic [15:0] XID_PB       = 16'h0004;
    localparam logic [15:0] XID_ACS      = 16'h000D;
    localparam logic [15:0] XID_LTR      = 16'h0018;
    localparam logic [11:0] XNXT_AER     = 12'h140;
    localparam logic [11:0] XNXT_VC      = 12'h20C;
    localparam logic [11:0] XNXT_PB_ACS  = 12'h220;
    localparam logic [11:0] XNXT_PB_LTR  = 12'h230;
    localparam logic [11:0] XNXT_END     = 12'h000;
    localparam logic [3:0]  CAP_VER      = 4'h1;
    localparam logic [7:0]  VC_ARB_OFS   = 8'h03;
    localparam logic [7:0]  PA0_OFS      = 8'h04;
    localparam logic [7:0]  PA1_OFS      = 8'h06;
    localparam int          ARB_WORDS    = 36;
    localparam int          PA0_IDX      = 4;
    localparam int          PA1_IDX      = 20;

    // Read-only contents held outside this map; neutral defaults
    localparam logic [31:0] SSID_VAL     = 32'h0000_0000;
    localparam logic [31:0] RO_CAP_VAL   = 32'h0000_0000;
    localparam logic [31:0] PB_DATA_VAL  = 32'h0000_0000;

    // Writable bit masks and values after reset
    localparam logic [31:0] WM_FULL      = 32'hFFFF_FFFF;
    localparam logic [31:0] WM_LOW       = 32'h0000_FFFF;
    localparam logic [31:0] WM_HIGH      = 32'hFFFF_0000;
    localparam logic [31:0] WM_BYTE      = 32'h0000_00FF;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [2:0]  RST_SYNC     = 3'h0;

    // Whole register state of the map
    typedef struct packed {
        spcm_rsp_t                   rsp;
        logic [31:0]                 phy3;
        logic [31:0]                 phy_tx;
        logic [31:0]                 op_buf;
        logic [31:0]                 gpio;
        logic [31:0]                 rom;
        logic [31:0]                 dev_ctl;
        logic [31:0]                 lnk_ctl;
        logic [31:0]                 slt_ctl;
        logic [31:0]                 dev_ctl2;
        logic [31:0]                 lnk_ctl2;
        logic [31:0]                 ue_sts;
        logic [31:0]                 ue_msk;
        logic [31:0]                 ue_sev;
        logic [31:0]                 ce_sts;
        logic [31:0]                 ce_msk;
        logic [31:0]                 aer_ctl;
        logic [31:0]                 vc_ctl;
        logic [31:0]                 vc0_ctl;
        logic [31:0]                 vc1_ctl;
        logic [31:0]                 pb_sel;
        logic [31:0]                 pb_cap;
        logic [31:0]                 acs_ctl;
        logic [31:0]                 egress;
        logic [31:0]                 ltr_val;
        logic [ARB_WORDS-1:0][31:0]  arb;
        logic [2:0]                  ltr_sync;
        logic                        ltr_sel;
        logic                        err_pend;
    } spcm_state_t;

endpackage

// ===== bench/spcm_host.sv
// Host model issuing configuration reads and writes to the port map
`timescale 1ns/1ns
module spcm_host
    import spcm_pkg::*;
(
    input  wire logic    clk,
    output spcm_req_t    cfg_req,
    input  spcm_rsp_t    cfg_rsp
);
    initial cfg_req = '0;
    // One dword per request; released lines show inverted data so stale values never match
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1 cfg_req = '{req: 1'b1, wr: wr, addr: a, be: 4'hF, wdata: d};
        @(posedge clk);
        #1 q = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : 'x;
        cfg_req = '{req: 1'b0, wr: ~wr, addr: ~a, be: 4'h0, wdata: ~d};
    endtask
    // Write, then two reads of the same dword on consecutive edges
    task automatic wr_rd2(input logic [11:0] a, input logic [31:0] d, output logic [31:0] q0,
                          output logic [31:0] q1);
        @(posedge clk);
        #1 cfg_req = '{req: 1'b1, wr: 1'b1, addr: a, be: 4'hF, wdata: d};
        @(posedge clk);
        #1 cfg_req = '{req: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: ~d};
        @(posedge clk);
        #1 q0 = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : 'x;
        @(posedge clk);
        #1 q1 = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : 'x;
        cfg_req = '{req: 1'b0, wr: 1'b1, addr: ~a, be: 4'h0, wdata: d};
    endtask
endmodule

// ===== bench/spcm_cfg_map_bench.sv
// Self-checking bench for the port configuration capability map
`timescale 1ns/1ns
module spcm_cfg_map_bench;
    import spcm_pkg::*;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic [31:0] ue_event = 32'h0;
    logic [31:0] ce_event = 32'h0;
    logic        ltr_pin  = 1'b0;
    spcm_req_t   req;
    spcm_rsp_t   rsp;
    logic [31:0] q;
    logic [31:0] q2;
    logic        err_pend;
    logic        ltr_sel;
    int          err_total = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    logic [11:0] ta [8]    = '{12'h170, 12'h17C, 12'h180, 12'h1BC, 12'h1C0, 12'h1FC, 12'h234, 12'h108};
    logic [11:0] ra [3]    = '{12'h12C, 12'h200, 12'h0F8};

    spcm_cfg_map dut (.clk(clk), .rst(rst), .cfg_req(req), .ue_event(ue_event), .ce_event(ce_event),
        .hdr_log({32'hD3D3_0003, 32'hC2C2_0002, 32'hB1B1_0001, 32'hA0A0_0000}), .ltr_route_pin(ltr_pin),
        .cfg_rsp(rsp), .err_pending(err_pend), .ltr_route(ltr_sel));
    spcm_host host (.clk(clk), .cfg_req(req), .cfg_rsp(rsp));

    // Free-running clock, 4 ns period
    initial forever #2 clk = ~clk;

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Read a dword and compare the masked bits
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        n_checks++;
        if ((q & m) !== e)
        begin
            $display("[ERR] dword %h: expected %h, seen %h", a, e, q & m);
            err_total++;
        end
    endtask

    // Compare a sampled value against its expectation
    task automatic val_chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("[ERR] %s: expected %h, seen %h", nm, e, s);
            err_total++;
        end
    endtask

    // Hang guard; the whole sequence needs well under 200 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        rd_chk(12'h100, '1, 32'h1401_0001);
        rd_chk(12'h140, '1, 32'h20C1_0002);
        rd_chk(12'h220, '1, 32'h0001_000D);
        rd_chk(12'h230, '1, 32'h0001_0018);
        rd_chk(12'h148, 32'hFF00_0000, 32'h0300_0000);
        rd_chk(12'h150, 32'hFF00_0000, 32'h0400_0000);
        rd_chk(12'h15C, 32'hFF00_0000, 32'h0600_0000);
        rd_chk(12'h0B0, '1, 32'h0000_C00D);
        rd_chk(12'h0C0, '1, 32'h0000_0010);
        rd_chk(12'h11C, '1, 32'hA0A0_0000);
        rd_chk(12'h128, '1, 32'hD3D3_0003);
        rd_chk(12'h20C, '1, 32'h2201_0004);
        // Strap moves the power budget pointer once the filter settles
        ltr_pin = 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(12'h20C, '1, 32'h2301_0004);
        val_chk("ltr_route", 32'h1, {31'h0, ltr_sel});
        // Table ends and writable dwords keep their own values
        foreach (ta[i]) host.xfer(1'b1, ta[i], {20'hC3A59, ta[i]}, q);
        foreach (ta[i]) rd_chk(ta[i], '1, {20'hC3A59, ta[i]});
        // Write seen by a read taken on the very next edge
        host.wr_rd2(12'h1A0, 32'h5A5A_1A0F, q, q2);
        val_chk("table 1A0 first read", 32'h5A5A_1A0F, q);
        val_chk("table 1A0 second read", 32'h5A5A_1A0F, q2);
        foreach (ra[i]) host.xfer(1'b1, ra[i], 32'hFFFF_FFFF, q);
        foreach (ra[i]) rd_chk(ra[i], '1, 32'h0);
        // Error status sets on an event, survives a clear in the same cycle, then clears
        @(posedge clk);
        #1 ue_event = 32'h0000_0020;
        ce_event = 32'h0000_0001;
        @(posedge clk);
        #1 ue_event = 32'h0;
        ce_event = 32'h0;
        rd_chk(12'h104, 32'h0000_0020, 32'h0000_0020);
        rd_chk(12'h110, 32'h0000_0001, 32'h0000_0001);
        val_chk("err_pending set", 32'h1, {31'h0, err_pend});
        fork
            host.xfer(1'b1, 12'h104, 32'h0000_0020, q);
            begin
                @(posedge clk);
                #1 ue_event = 32'h0000_0020;
                @(posedge clk);
                #1 ue_event = 32'h0;
            end
        join
        rd_chk(12'h104, 32'h0000_0020, 32'h0000_0020);
        host.xfer(1'b1, 12'h104, 32'h0000_0020, q);
        host.xfer(1'b1, 12'h110, 32'h0000_0001, q);
        rd_chk(12'h104, 32'h0000_0020, 32'h0);
        val_chk("err_pending clear", 32'h0, {31'h0, err_pend});
        give_verdict();
    end
endmodule
